// File: logic/adc_conversion_sequencer.sv
/*
 * converter conversion sequencer: control registers, start detection,
 * sample and convert phases timed by a divided clock, busy and request
 * flags, interrupt line and justified result bytes.
 * assumes the analog converter presents a settled 12-bit result on
 * conv_data at the end of the conversion phase, and a register master
 * that holds strobes one cycle, never both at once.
 */
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`include "adc_seq_consts.svh"
module adc_conversion_sequencer import adc_seq_pkg::*; #(
    parameter int DATA_W = 12
) (
    input logic clk_sys,
    input logic rst_b,
    input reg_req_t req,
    output logic [7:0] rdata,
    input logic [DATA_W-1:0] conv_data,
    output analog_ctl_t analog_ctl,
    output logic conv_irq
);
    seq_state_t s_r;
    seq_state_t s_nxt;
    logic tick;
    logic launch;
    logic done;
    logic abort;
    logic ext_src;
    logic [7:0] just_hi;
    logic [7:0] just_lo;

    // -------------------------------------------------------------------
    // submodules
    // -------------------------------------------------------------------

    // converter clock ticks, restarted at each launch
    conv_clock_divider #(
        .SEL_W(3),
        .CNT_W(7)
    ) conv_clock_divider_i (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .clr(launch),
        .sel(s_r.div),
        .tick(tick)
    );

    // result byte placement
    result_justifier result_justifier_i (
        .data(conv_data),
        .fmt(s_r.fmt),
        .hi(just_hi),
        .lo(just_lo)
    );

    // -------------------------------------------------------------------
    // next state
    // -------------------------------------------------------------------

    // source code decode: external codes 0000, 0100 and 11xx
    always_comb begin
        ext_src = (s_nxt_src() == 4'h0) || (s_nxt_src() == 4'h4) ||
            (s_nxt_src() >= 4'hc);
    end

    function automatic logic [3:0] s_nxt_src();
        return (req.wr && req.addr == `REG_CTRL1) ? req.wdata[`C1_SRC] : s_r.src;
    endfunction : s_nxt_src

    always_comb begin
        s_nxt = s_r;
        launch = 1'b0;
        done = 1'b0;
        abort = 1'b0;

        // phase sequencing, runs without software help
        case (s_r.phase)
            PH_IDLE: begin
                s_nxt.ticks = 4'h0;
            end
            PH_SAMPLE: begin
                if (tick) begin
                    if (s_r.ticks == `SAMPLE_TICKS - 4'h1) begin
                        s_nxt.phase = PH_CONVERT;
                        s_nxt.ticks = 4'h0;
                    end else begin
                        s_nxt.ticks = s_r.ticks + 4'h1;
                    end
                end
            end
            PH_CONVERT: begin
                if (tick) begin
                    if (s_r.ticks == `CONV_TICKS - 4'h1) begin
                        done = 1'b1;
                        s_nxt.phase = PH_IDLE;
                        s_nxt.ticks = 4'h0;
                        s_nxt.busy = 1'b0;
                        s_nxt.res_hi = just_hi;
                        s_nxt.res_lo = just_lo;
                    end else begin
                        s_nxt.ticks = s_r.ticks + 4'h1;
                    end
                end
            end
            default: begin
                s_nxt.phase = PH_IDLE;
                s_nxt.ticks = 4'h0;
            end
        endcase

        // register writes
        if (req.wr) begin
            case (req.addr)
                `REG_CTRL0: begin
                    s_nxt.start = req.wdata[`C0_START];
                    s_nxt.pwr = req.wdata[`C0_PWR];
                    s_nxt.fmt = req.wdata[`C0_FMT];
                    s_nxt.ext_ch = req.wdata[`C0_EXT];
                    // falling start bit with power on launches
                    if (s_r.start && !req.wdata[`C0_START] && req.wdata[`C0_PWR]) begin
                        launch = 1'b1;
                    end
                end
                `REG_CTRL1: begin
                    s_nxt.src = req.wdata[`C1_SRC];
                    s_nxt.div = req.wdata[`C1_DIV];
                end
                `REG_CTRL2: begin
                    s_nxt.amp_en = req.wdata[`C2_AMPEN];
                    s_nxt.amp_in = req.wdata[`C2_AMPIN];
                    s_nxt.ref_sel = req.wdata[`C2_REF];
                    s_nxt.gain = req.wdata[`C2_GAIN];
                end
                `REG_INT: begin
                    s_nxt.gie = req.wdata[`INT_GIE];
                    s_nxt.cie = req.wdata[`INT_CIE];
                    s_nxt.flag = req.wdata[`INT_FLAG];
                end
                default: begin
                    s_nxt.start = s_nxt.start;
                end
            endcase
        end

        // power dropped mid conversion abandons it
        if (!s_nxt.pwr && s_r.phase != PH_IDLE && !done) begin
            abort = 1'b1;
            s_nxt.phase = PH_IDLE;
            s_nxt.busy = 1'b0;
            s_nxt.ticks = 4'h0;
        end

        // launch restarts the sample phase
        if (launch) begin
            s_nxt.phase = PH_SAMPLE;
            s_nxt.ticks = 4'h0;
            s_nxt.busy = 1'b1;
        end

        // completion wins over a software clear
        if (done) begin
            s_nxt.flag = 1'b1;
        end
        s_nxt.irq = s_nxt.flag && s_nxt.cie && s_nxt.gie;

        // input routing: internal codes cut every external channel
        s_nxt.ext_en = s_nxt.pwr && ext_src;
        s_nxt.int_sel = ext_src ? 4'h0 : s_nxt.src;

        // read data for one cycle only
        s_nxt.rdata = `RST_BYTE;
        if (req.rd) begin
            case (req.addr)
                `REG_CTRL0: s_nxt.rdata = {s_r.start, s_r.busy, s_r.pwr, s_r.fmt, s_r.ext_ch};
                `REG_CTRL1: s_nxt.rdata = {s_r.src, 1'b0, s_r.div};
                `REG_CTRL2: s_nxt.rdata = {s_r.amp_en, 2'b00, s_r.amp_in, s_r.ref_sel, s_r.gain};
                `REG_RES_HI: s_nxt.rdata = s_r.res_hi;
                `REG_RES_LO: s_nxt.rdata = s_r.res_lo;
                `REG_INT: s_nxt.rdata = {5'h00, s_r.flag, s_r.cie, s_r.gie};
                default: s_nxt.rdata = `RST_BYTE;
            endcase
        end
    end

    // -------------------------------------------------------------------
    // state register
    // -------------------------------------------------------------------

    // whole state in one flop group
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from the state flops
    assign rdata = s_r.rdata;
    assign conv_irq = s_r.irq;
    assign analog_ctl.power_en = s_r.pwr;
    assign analog_ctl.sampling = s_r.phase[0]; // phase code low bit marks the sample phase
    assign analog_ctl.ext_route_en = s_r.ext_en;
    assign analog_ctl.external_channel_sel = s_r.ext_ch;
    assign analog_ctl.internal_sel = s_r.int_sel;
    assign analog_ctl.reference_source_sel = s_r.ref_sel;
    assign analog_ctl.ref_amp_en = s_r.amp_en;
    assign analog_ctl.ref_amp_input_sel = s_r.amp_in;
    assign analog_ctl.ref_amp_gain_sel = s_r.gain;

    // -------------------------------------------------------------------
    // checks
    // -------------------------------------------------------------------

    // converter ticks since the last launch
    logic [4:0] chk_ticks;
    logic [7:0] chk_hi;
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            chk_ticks <= 5'h00;
        end else if (launch) begin
            chk_ticks <= 5'h00;
        end else if (tick && s_r.busy) begin
            chk_ticks <= chk_ticks + 5'h01;
        end
    end

    // expected left-justified high byte
    assign chk_hi = conv_data[11:4];

    // external source codes decoded again from the stored field
    logic chk_ext_code;
    assign chk_ext_code = (s_r.src == 4'h0) || (s_r.src == 4'h4) || (s_r.src[3:2] == 2'b11);

    // system clocks since the last converter tick, zeroed at launch
    logic [7:0] chk_gap;
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            chk_gap <= 8'h00;
        end else if (launch) begin
            chk_gap <= 8'h00;
        end else if (tick) begin
            chk_gap <= 8'h01;
        end else begin
            chk_gap <= chk_gap + 8'h01;
        end
    end

    launch_sets_busy_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        launch |=> s_r.busy && s_r.phase == PH_SAMPLE)
        else $error("busy not raised after launch");

    done_clears_busy_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (done && !launch) |=> !s_r.busy)
        else $error("busy still high after completion");

    done_sets_flag_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        done |=> s_r.flag)
        else $error("request flag not set on completion");

    irq_follows_flag_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (done && s_r.cie && s_r.gie && !(req.wr && req.addr == `REG_INT)) |=> conv_irq)
        else $error("interrupt line not raised on completion");

    sixteen_ticks_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        done |-> chk_ticks == 5'h0f)
        else $error("conversion did not take sixteen converter clocks");

    sample_phase_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (s_r.phase == PH_SAMPLE && s_nxt.phase == PH_CONVERT) |-> chk_ticks == 5'h03 && tick)
        else $error("sample phase not four converter clocks");

    internal_cuts_ext_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !chk_ext_code |-> !s_r.ext_en)
        else $error("external route open while internal source chosen");

    result_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !done |=> $stable(s_r.res_hi) && $stable(s_r.res_lo))
        else $error("result changed without completion");

    left_justify_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (done && !s_r.fmt) |=> s_r.res_hi == $past(chk_hi) && s_r.res_lo[3:0] == 4'h0)
        else $error("left justified result misplaced");

    right_justify_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (done && s_r.fmt) |=> s_r.res_hi[7:4] == 4'h0 && s_r.res_lo == $past(conv_data[7:0]))
        else $error("right justified result misplaced");

    no_power_no_launch_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (s_r.phase != PH_IDLE) |-> s_r.pwr)
        else $error("conversion running without power");

    read_one_cycle_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !req.rd |=> rdata == 8'h00)
        else $error("read data outside the read answer cycle");

    start_pulse_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (req.wr && req.addr == `REG_CTRL0 && s_r.start && !req.wdata[`C0_START] &&
            req.wdata[`C0_PWR]) |=> s_r.busy && s_r.phase == PH_SAMPLE && s_r.ticks == 4'h0)
        else $error("start pulse did not launch a conversion");

    phase_busy_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (s_r.phase != PH_IDLE) == s_r.busy)
        else $error("busy flag disagrees with the phase");

    busy_rise_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        $rose(s_r.busy) |-> $past(launch))
        else $error("busy rose without a launch");

    sampling_busy_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        analog_ctl.sampling |-> s_r.busy)
        else $error("sampling outside a conversion");

    abort_idle_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        abort |=> !s_r.busy && s_r.phase == PH_IDLE)
        else $error("abort left the sequencer running");

    abort_flag_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (abort && !(req.wr && req.addr == `REG_INT)) |=> $stable(s_r.flag))
        else $error("abort changed the request flag");

    unpowered_start_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (req.wr && req.addr == `REG_CTRL0 && !req.wdata[`C0_PWR]) |=> !s_r.busy)
        else $error("busy with converter power off");

    flag_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (req.wr && req.addr == `REG_INT && !req.wdata[`INT_FLAG] && !done) |=> !s_r.flag)
        else $error("request flag not cleared by software");

    read_high_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (req.rd && req.addr == `REG_RES_HI) |=> rdata == $past(s_r.res_hi))
        else $error("high result byte read wrong");

    read_low_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (req.rd && req.addr == `REG_RES_LO) |=> rdata == $past(s_r.res_lo))
        else $error("low result byte read wrong");

    ext_route_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        chk_ext_code |-> s_r.int_sel == 4'h0 && s_r.ext_en == s_r.pwr)
        else $error("external source not routed");

    int_code_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !chk_ext_code |-> s_r.int_sel == s_r.src)
        else $error("internal source code not passed on");

    tick_gap_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (tick && s_r.busy) |-> chk_gap == (8'h01 << s_r.div))
        else $error("converter tick spacing wrong for divider");

endmodule : adc_conversion_sequencer

// File: logic/adc_seq_consts.svh
/*
 * constants of the converter sequencer: register indices, field positions,
 * reset values and phase lengths.
 * assumes an 8-bit register port with a 3-bit register index.
 */
`ifndef ADC_SEQ_CONSTS_SVH
`define ADC_SEQ_CONSTS_SVH

// -------------------------------------------------------------------
// register indices
// -------------------------------------------------------------------
`define REG_CTRL0 3'h0
`define REG_CTRL1 3'h1
`define REG_CTRL2 3'h2
`define REG_RES_HI 3'h3
`define REG_RES_LO 3'h4
`define REG_INT 3'h5

// -------------------------------------------------------------------
// field positions
// -------------------------------------------------------------------
`define C0_START 7
`define C0_BUSY 6
`define C0_PWR 5
`define C0_FMT 4
`define C0_EXT 3:0
`define C1_SRC 7:4
`define C1_DIV 2:0
`define C2_AMPEN 7
`define C2_AMPIN 4
`define C2_REF 3:2
`define C2_GAIN 1:0
`define INT_GIE 0
`define INT_CIE 1
`define INT_FLAG 2

// -------------------------------------------------------------------
// reset values and phase lengths
// -------------------------------------------------------------------
`define RST_BYTE 8'h00
`define SAMPLE_TICKS 4'h4
`define CONV_TICKS 4'hc

`endif

// File: logic/adc_seq_pkg.sv
/*
 * types of the converter sequencer.
 * assumes adc_seq_consts.svh is included where field positions are needed.
 */
package adc_seq_pkg;

    // -------------------------------------------------------------------
    // sequencer phases
    // -------------------------------------------------------------------
    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_SAMPLE = 2'b01,
        PH_CONVERT = 2'b10
    } phase_t;

    // register port request
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    // controls toward the analog converter
    typedef struct packed {
        logic power_en;
        logic sampling;
        logic ext_route_en;
        logic [3:0] external_channel_sel;
        logic [3:0] internal_sel;
        logic [1:0] reference_source_sel;
        logic ref_amp_en;
        logic ref_amp_input_sel;
        logic [1:0] ref_amp_gain_sel;
    } analog_ctl_t;

    // divider state
    typedef struct packed {
        logic [6:0] cnt;
        logic tick;
    } div_state_t;

    // sequencer state
    typedef struct packed {
        logic start;
        logic pwr;
        logic fmt;
        logic [3:0] ext_ch;
        logic [3:0] src;
        logic [2:0] div;
        logic amp_en;
        logic amp_in;
        logic [1:0] ref_sel;
        logic [1:0] gain;
        logic gie;
        logic cie;
        logic flag;
        logic busy;
        phase_t phase;
        logic [3:0] ticks;
        logic [7:0] res_hi;
        logic [7:0] res_lo;
        logic [7:0] rdata;
        logic irq;
        logic ext_en;
        logic [3:0] int_sel;
    } seq_state_t;

endpackage : adc_seq_pkg

// File: logic/conv_clock_divider.sv
/*
 * converter clock tick generator: one-cycle tick every 2**sel system clocks.
 * assumes a clear pulse on each launch so the first tick is a full period away.
 */
`include "adc_seq_consts.svh"
module conv_clock_divider import adc_seq_pkg::*; #(
    parameter int SEL_W = 3,
    parameter int CNT_W = 7
) (
    input logic clk_sys,
    input logic rst_b,
    input logic clr,
    input logic [SEL_W-1:0] sel,
    output logic tick
);
    div_state_t s_r;
    div_state_t s_nxt;
    logic [CNT_W-1:0] mask;

    // free counter; tick when the low sel bits are all ones
    always_comb begin
        s_nxt = s_r;
        mask = CNT_W'((1 << sel) - 1);
        s_nxt.tick = ((s_r.cnt & mask) == mask) && !clr;
        s_nxt.cnt = clr ? '0 : s_r.cnt + 1'b1;
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign tick = s_r.tick;

    div_spacing_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (tick && $past(sel) != '0 && sel != '0 && !clr) |=> !tick)
        else $error("divided tick on two adjacent cycles");
endmodule : conv_clock_divider

// File: logic/result_justifier.sv
/*
 * places a 12-bit result into two bytes, left or right justified.
 * assumes the caller registers the two bytes.
 */
module result_justifier (
    input logic [11:0] data,
    input logic fmt,
    output logic [7:0] hi,
    output logic [7:0] lo
);
    // format 0 left justified, format 1 right justified
    always_comb begin
        if (fmt) begin
            hi = {4'h0, data[11:8]};
            lo = data[7:0];
        end else begin
            hi = data[11:4];
            lo = {data[3:0], 4'h0};
        end
    end
endmodule : result_justifier

// File: tb/adc_conversion_sequencer_tb_top.sv
/*
 * self-checking bench of the converter sequencer: register port, routing,
 * conversion timing over every divider code, result bytes, flag and abort.
 * assumes the package and consts header are compiled first; no analog model,
 * conv_data is held steady by the bench during each conversion.
 */
`include "adc_seq_consts.svh"
module adc_conversion_sequencer_tb_top import adc_seq_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    reg_req_t req = '0;
    logic [7:0] rdata;
    logic [11:0] conv_data = 12'h000;
    analog_ctl_t analog_ctl;
    logic conv_irq;
    int n_errors = 0;
    int checks = 0;
    int samp_cnt = 0;
    logic [7:0] exp_hi = 8'h00;
    logic [7:0] exp_lo = 8'h00;

    adc_conversion_sequencer adc_conversion_sequencer_i (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .req(req),
        .rdata(rdata),
        .conv_data(conv_data),
        .analog_ctl(analog_ctl),
        .conv_irq(conv_irq)
    );

    // ---------------------------------------------------------------
    // clock and sample-phase counter
    // ---------------------------------------------------------------
    always #20 clk_sys = ~clk_sys;

    always @(posedge clk_sys) begin
        if (analog_ctl.sampling === 1'b1) samp_cnt <= samp_cnt + 1;
    end

    // ---------------------------------------------------------------
    // report and compare
    // ---------------------------------------------------------------
    task automatic give_verdict;
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : give_verdict

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk_byte

    task automatic chk_bit(input logic got, input logic exp, input string what);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask : chk_bit

    // ---------------------------------------------------------------
    // register port cycles
    // ---------------------------------------------------------------
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        req.addr <= a;
        req.wdata <= d;
        req.wr <= 1'b1;
        @(posedge clk_sys);
        req.wr <= 1'b0;
    endtask : wr

    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        req.addr <= a;
        req.rd <= 1'b1;
        @(posedge clk_sys);
        req.rd <= 1'b0;
        #1 d = rdata;
    endtask : rd

    // start bit high then low, power held on, external channel 3
    task automatic launch(input logic [2:0] k, input logic fmt);
        wr(`REG_CTRL1, {5'h00, k});
        wr(`REG_CTRL0, {3'b101, fmt, 4'h3});
        wr(`REG_CTRL0, {3'b001, fmt, 4'h3});
    endtask : launch

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_reset_regs;
        logic [7:0] d;
        for (int i = 0; i < 8; i++) begin
            rd(i[2:0], d);
            chk_byte(d, 8'h00, "reset value");
        end
        chk_bit(conv_irq, 1'b0, "irq at reset");
        wr(3'h6, 8'hff);
        rd(3'h6, d);
        chk_byte(d, 8'h00, "unmapped read");
        wr(`REG_CTRL0, 8'h40);
        rd(`REG_CTRL0, d);
        chk_byte(d, 8'h00, "busy read-only");
        wr(`REG_CTRL2, 8'h9e);
        rd(`REG_CTRL2, d);
        chk_byte(d, 8'h9e, "ctrl2 readback");
        chk_byte({6'h00, analog_ctl.reference_source_sel}, 8'h03, "ref sel");
        chk_byte({4'h0, analog_ctl.ref_amp_en, analog_ctl.ref_amp_input_sel, analog_ctl.ref_amp_gain_sel},
                 8'h0e, "amp fields");
    endtask : t_reset_regs

    task automatic t_routing;
        logic ext;
        wr(`REG_CTRL0, 8'h23);
        #1 chk_bit(analog_ctl.power_en, 1'b1, "power enable");
        for (int s = 0; s < 16; s++) begin
            wr(`REG_CTRL1, {s[3:0], 4'h0});
            repeat (2) @(posedge clk_sys);
            #1 ext = (s == 0) || (s == 4) || (s[3:2] == 2'b11);
            chk_bit(analog_ctl.ext_route_en, ext, "external route");
            chk_byte({4'h0, analog_ctl.internal_sel}, ext ? 8'h00 : {4'h0, s[3:0]}, "internal sel");
            chk_byte({4'h0, analog_ctl.external_channel_sel}, 8'h03, "channel sel");
        end
        wr(`REG_CTRL1, 8'h00);
    endtask : t_routing

    // every divider code, alternating format, irq enabled
    task automatic t_convert_all;
        logic [7:0] d;
        logic [11:0] v;
        int n;
        int s0;
        wr(`REG_INT, 8'h03);
        repeat (4) @(posedge clk_sys);
        for (int k = 0; k < 8; k++) begin
            v = 12'ha5c ^ {k[3:0], 8'h31};
            @(posedge clk_sys);
            conv_data <= v;
            exp_hi = k[0] ? {4'h0, v[11:8]} : v[11:4];
            exp_lo = k[0] ? v[7:0] : {v[3:0], 4'h0};
            launch(k[2:0], k[0]);
            s0 = samp_cnt;
            rd(`REG_CTRL0, d);
            chk_byte(d & 8'h40, 8'h40, "busy after start");
            n = 2;
            while (conv_irq !== 1'b1) begin
                @(posedge clk_sys);
                #1 n++;
                if (n > 3000) begin
                    n_errors++;
                    give_verdict();
                end
            end
            chk_bit(n >= (16 << k) && n <= (16 << k) + 2, 1'b1, "conversion length");
            chk_bit(samp_cnt - s0 >= (4 << k) && samp_cnt - s0 <= (4 << k) + 1, 1'b1, "sample length");
            rd(`REG_CTRL0, d);
            chk_byte(d & 8'h40, 8'h00, "busy cleared");
            rd(`REG_INT, d);
            chk_byte(d, 8'h07, "request flag");
            rd(`REG_RES_HI, d);
            chk_byte(d, exp_hi, "result high");
            rd(`REG_RES_LO, d);
            chk_byte(d, exp_lo, "result low");
            wr(`REG_INT, 8'h03);
            @(posedge clk_sys);
            #1 chk_bit(conv_irq, 1'b0, "irq after clear");
        end
    endtask : t_convert_all

    // flag without converter enable keeps the line low until enabled
    task automatic t_irq_gate;
        logic [7:0] d;
        wr(`REG_INT, 8'h01);
        launch(3'h0, 1'b0);
        repeat (30) @(posedge clk_sys);
        rd(`REG_INT, d);
        chk_byte(d, 8'h05, "flag without enable");
        chk_bit(conv_irq, 1'b0, "irq gated");
        exp_hi = conv_data[11:4];
        exp_lo = {conv_data[3:0], 4'h0};
        wr(`REG_INT, 8'h07);
        repeat (2) @(posedge clk_sys);
        #1 chk_bit(conv_irq, 1'b1, "irq enabled");
        wr(`REG_INT, 8'h03);
    endtask : t_irq_gate

    // power removed mid-conversion, and a start with power off
    task automatic t_abort;
        logic [7:0] d;
        @(posedge clk_sys);
        conv_data <= 12'h3c6;
        launch(3'h4, 1'b0);
        repeat (10) @(posedge clk_sys);
        wr(`REG_CTRL0, 8'h00);
        rd(`REG_CTRL0, d);
        chk_byte(d, 8'h00, "busy after abort");
        repeat (200) @(posedge clk_sys);
        rd(`REG_INT, d);
        chk_byte(d, 8'h03, "no flag after abort");
        rd(`REG_RES_HI, d);
        chk_byte(d, exp_hi, "high held");
        rd(`REG_RES_LO, d);
        chk_byte(d, exp_lo, "low held");
        wr(`REG_CTRL0, 8'h80);
        wr(`REG_CTRL0, 8'h00);
        rd(`REG_CTRL0, d);
        chk_byte(d, 8'h00, "start unpowered");
        chk_bit(analog_ctl.power_en, 1'b0, "power off");
    endtask : t_abort

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        repeat (5) @(posedge clk_sys);
        rst_b <= 1'b1;
        t_reset_regs();
        t_routing();
        t_convert_all();
        t_irq_gate();
        t_abort();
        give_verdict();
    end

endmodule : adc_conversion_sequencer_tb_top
